// ---- logic/i2c_arb_defs.svh ----
// Register offsets, field positions and reset values of the arbitrating I2C master.
`ifndef I2C_ARB_DEFS_SVH
`define I2C_ARB_DEFS_SVH
// ==========================================
// Register offsets.
`define OFF_CTRL 3'h0
`define OFF_CMD 3'h1
`define OFF_STAT 3'h2
`define OFF_DIV 3'h3
`define OFF_BUF 3'h4
// ==========================================
// Control register fields.
`define CTRL_EN 0
`define CTRL_IE 1
// ==========================================
// Second control register fields.
`define CMD_START 0
`define CMD_RSTART 1
`define CMD_STOP 2
`define CMD_ACK 3
`define CMD_ACKDT 4
`define CMD_ACKSTAT 5
// ==========================================
// Port status register fields.
`define ST_START 0
`define ST_STOP 1
`define ST_BF 2
`define ST_COLL 3
`define ST_IRQ 4
`define ST_BUSY 5
// ==========================================
// Reset values and the acknowledge slot number.
`define DIV_RST 8'h09
`define BYTE_ZERO 8'h00
`define ACK_SLOT 4'h8
`endif

// ---- logic/i2c_arb_pkg.sv ----
// Types shared by the arbitrating I2C master.
package i2c_arb_pkg;
	// Sequencer states.
	typedef enum logic [4:0] {
		S_IDLE, S_ST_CHK, S_ST_C1, S_ST_C2,
		S_RS_REL, S_RS_C1, S_RS_SCL, S_RS_C2, S_RS_C3,
		S_B_LOW, S_B_REL, S_B_HIGH,
		S_SP_LOW, S_SP_C1, S_SP_SCL, S_SP_C2, S_SP_C3
	} state_e;
	// One sample of the two bus lines.
	typedef struct packed {
		logic scl;
		logic sda;
	} lines_s;
endpackage : i2c_arb_pkg

// ---- logic/i2c_arb.sv ----
// Arbitrating I2C master: clock stretching, collision detection, bus monitor.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`include "i2c_arb_defs.svh"
module i2c_arb #(
	parameter int BRG_W = 7
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_n_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n_o,
	input wire logic sleep_i,
	output logic irq_o,
	output logic wake_o
);
	// ==========================================
	// Declarations.
	// Address match, used by every decoder.
	function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
		hit = (a == off);
	endfunction : hit

	i2c_arb_pkg::state_e state_reg; // Sequencer state.
	i2c_arb_pkg::lines_s sync1_reg; // First synchroniser stage.
	i2c_arb_pkg::lines_s sync2_reg; // Synchronised lines.
	i2c_arb_pkg::lines_s prev_reg; // Lines one cycle earlier.
	i2c_arb_pkg::lines_s out_reg; // Open-drain data, always low.
	logic [BRG_W-1:0] brg_reg; // Baud counter.
	logic [3:0] bit_cnt_reg; // Bit slot within a byte.
	logic [7:0] shift_reg; // Outgoing byte.
	logic ack_seq_reg; // Bit states run an acknowledge.
	logic drv_scl_reg; // Pull SCL low.
	logic drv_sda_reg; // Pull SDA low.
	logic ackstat_reg; // No acknowledge seen from slave.
	logic coll_pulse_reg; // Collision event.
	logic done_pulse_reg; // Sequence finished.
	logic byte_pulse_reg; // Byte transfer finished.
	logic en_reg; // Port enable.
	logic ie_reg; // Port interrupt enable.
	logic [3:0] cmd_reg; // Sequence enables.
	logic ackdt_reg; // Acknowledge data to send.
	logic [7:0] div_reg; // Baud divider register.
	logic [7:0] buf_reg; // Transfer buffer.
	logic bf_reg; // Buffer full flag.
	logic coll_flag_reg; // Collision flag.
	logic irq_flag_reg; // Port interrupt flag.
	logic start_seen_reg; // Start seen on bus.
	logic stop_seen_reg; // Stop seen on bus.
	logic watch_reg; // Lost arbitration, waiting for Stop.
	logic [7:0] rdata_reg; // Read data.
	logic irq_reg; // Interrupt output.
	logic wake_reg; // Wake output.
	logic tick; // Baud counter at zero.
	logic [BRG_W-1:0] reload; // Baud reload value.
	logic start_det; // Start condition.
	logic stop_det; // Stop condition.
	logic quiet; // No event still settling.
	logic buf_wr; // Accepted buffer write.
	logic idle; // Sequencer free.
	logic ack_slot; // Slave acknowledge bit.

	assign tick = (brg_reg == '0);
	assign reload = div_reg[BRG_W-1:0];
	assign idle = (state_reg == i2c_arb_pkg::S_IDLE);
	assign quiet = !coll_pulse_reg && !done_pulse_reg && !byte_pulse_reg;
	assign buf_wr = wr_i && hit(addr_i, `OFF_BUF) && en_reg && idle && quiet && (cmd_reg == '0);
	assign ack_slot = !ack_seq_reg && (bit_cnt_reg == `ACK_SLOT);
	// A condition needs SCL high in both samples.
	assign start_det = prev_reg.scl && sync2_reg.scl && prev_reg.sda && !sync2_reg.sda;
	assign stop_det = prev_reg.scl && sync2_reg.scl && !prev_reg.sda && sync2_reg.sda;

	// ==========================================
	// Pin synchronisers.
	// Two stages; only the second and later are read.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync1_reg <= '1;
			sync2_reg <= '1;
			prev_reg <= '1;
		end else if (ce_i) begin
			sync1_reg <= '{scl: scl_i, sda: sda_i};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// ==========================================
	// Sequencer: Start, Repeated Start, bytes, acknowledge, Stop.
	// While the port is enabled, the baud counter only runs in counting states.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_reg <= i2c_arb_pkg::S_IDLE;
			brg_reg <= '0;
			bit_cnt_reg <= '0;
			shift_reg <= `BYTE_ZERO;
			ack_seq_reg <= 1'b0;
			drv_scl_reg <= 1'b0;
			drv_sda_reg <= 1'b0;
			ackstat_reg <= 1'b0;
			coll_pulse_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
			byte_pulse_reg <= 1'b0;
		end else if (ce_i) begin
			coll_pulse_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
			byte_pulse_reg <= 1'b0;
			if (!tick) begin
				brg_reg <= brg_reg - 1'b1;
			end
			if (!en_reg) begin
				// A disabled port lets go of both lines at once.
				state_reg <= i2c_arb_pkg::S_IDLE;
				drv_scl_reg <= 1'b0;
				drv_sda_reg <= 1'b0;
			end else begin
				case (state_reg)
				i2c_arb_pkg::S_IDLE: begin
					brg_reg <= '0;
					if (buf_wr) begin
						// Always from the first bit.
						shift_reg <= wdata_i;
						bit_cnt_reg <= '0;
						ack_seq_reg <= 1'b0;
						drv_sda_reg <= !wdata_i[7];
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_B_LOW;
					end else if (quiet && cmd_reg[`CMD_START]) begin
						drv_scl_reg <= 1'b0;
						drv_sda_reg <= 1'b0;
						state_reg <= i2c_arb_pkg::S_ST_CHK;
					end else if (quiet && cmd_reg[`CMD_RSTART]) begin
						drv_sda_reg <= 1'b0;
						state_reg <= i2c_arb_pkg::S_RS_REL;
					end else if (quiet && cmd_reg[`CMD_STOP]) begin
						drv_sda_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_SP_LOW;
					end else if (quiet && cmd_reg[`CMD_ACK]) begin
						ack_seq_reg <= 1'b1;
						drv_scl_reg <= 1'b1;
						drv_sda_reg <= !ackdt_reg;
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_B_LOW;
					end
				end
				i2c_arb_pkg::S_ST_CHK: begin
					if (!sync2_reg.sda || !sync2_reg.scl) begin
						coll_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end else begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_ST_C1;
					end
				end
				i2c_arb_pkg::S_ST_C1: begin
					if (!sync2_reg.sda) begin
						// Another master won the race; follow it.
						brg_reg <= reload;
						drv_sda_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_ST_C2;
					end else if (!sync2_reg.scl) begin
						coll_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end else if (tick) begin
						drv_sda_reg <= 1'b1;
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_ST_C2;
					end
				end
				i2c_arb_pkg::S_ST_C2: begin
					// SCL low is ignored here.
					if (tick) begin
						drv_scl_reg <= 1'b1;
						done_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end
				end
				i2c_arb_pkg::S_RS_REL: begin
					// Count starts once SDA floats high.
					if (sync2_reg.sda) begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_RS_C1;
					end
				end
				i2c_arb_pkg::S_RS_C1: begin
					if (tick) begin
						drv_scl_reg <= 1'b0;
						state_reg <= i2c_arb_pkg::S_RS_SCL;
					end
				end
				i2c_arb_pkg::S_RS_SCL: begin
					// Counter frozen while SCL is held low.
					brg_reg <= brg_reg;
					if (sync2_reg.scl && !sync2_reg.sda) begin
						coll_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end else if (sync2_reg.scl) begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_RS_C2;
					end
				end
				i2c_arb_pkg::S_RS_C2: begin
					// SCL falling here is a collision; SDA is not checked.
					if (!sync2_reg.scl) begin
						coll_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end else if (tick) begin
						drv_sda_reg <= 1'b1;
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_RS_C3;
					end
				end
				i2c_arb_pkg::S_RS_C3: begin
					if (tick) begin
						drv_scl_reg <= 1'b1;
						done_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end
				end
				i2c_arb_pkg::S_B_LOW: begin
					drv_scl_reg <= 1'b1;
					if (tick) begin
						drv_scl_reg <= 1'b0;
						state_reg <= i2c_arb_pkg::S_B_REL;
					end
				end
				i2c_arb_pkg::S_B_REL: begin
					// Clock stretching: wait for SCL really high.
					brg_reg <= brg_reg;
					if (sync2_reg.scl) begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_B_HIGH;
					end
				end
				i2c_arb_pkg::S_B_HIGH: begin
					if (!drv_sda_reg && !sync2_reg.sda && !ack_slot) begin
						// Data bits and master acknowledge; the slave acknowledge slot is exempt.
						coll_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end else if (tick) begin
						drv_scl_reg <= 1'b1;
						brg_reg <= reload;
						if (ack_slot) begin
							ackstat_reg <= sync2_reg.sda;
						end
						if (ack_seq_reg) begin
							done_pulse_reg <= 1'b1;
							state_reg <= i2c_arb_pkg::S_IDLE;
						end else if (ack_slot) begin
							byte_pulse_reg <= 1'b1;
							state_reg <= i2c_arb_pkg::S_IDLE;
						end else begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							bit_cnt_reg <= bit_cnt_reg + 1'b1;
							// Slot eight releases SDA for the slave.
							drv_sda_reg <= (bit_cnt_reg == 4'h7) ? 1'b0 : !shift_reg[6];
							state_reg <= i2c_arb_pkg::S_B_LOW;
						end
					end
				end
				i2c_arb_pkg::S_SP_LOW: begin
					if (!sync2_reg.sda) begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_SP_C1;
					end
				end
				i2c_arb_pkg::S_SP_C1: begin
					if (tick) begin
						drv_scl_reg <= 1'b0;
						state_reg <= i2c_arb_pkg::S_SP_SCL;
					end
				end
				i2c_arb_pkg::S_SP_SCL: begin
					brg_reg <= brg_reg;
					if (sync2_reg.scl) begin
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_SP_C2;
					end
				end
				i2c_arb_pkg::S_SP_C2: begin
					if (tick) begin
						drv_sda_reg <= 1'b0;
						brg_reg <= reload;
						state_reg <= i2c_arb_pkg::S_SP_C3;
					end
				end
				i2c_arb_pkg::S_SP_C3: begin
					if (tick) begin
						done_pulse_reg <= 1'b1;
						state_reg <= i2c_arb_pkg::S_IDLE;
					end
				end
				default: begin
					state_reg <= i2c_arb_pkg::S_IDLE;
				end
				endcase
				if (coll_pulse_reg) begin
					// Let go of both lines after losing.
					drv_scl_reg <= 1'b0;
					drv_sda_reg <= 1'b0;
					bit_cnt_reg <= '0;
				end
			end
		end
	end

	// ==========================================
	// Control, divider and sequence-enable registers.
	// A command is taken only while the port is idle.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			en_reg <= 1'b0;
			ie_reg <= 1'b0;
			cmd_reg <= '0;
			ackdt_reg <= 1'b0;
			div_reg <= `DIV_RST;
			buf_reg <= `BYTE_ZERO;
		end else if (ce_i) begin
			if (wr_i && hit(addr_i, `OFF_CTRL)) begin
				en_reg <= wdata_i[`CTRL_EN];
				ie_reg <= wdata_i[`CTRL_IE];
			end else if (wr_i && hit(addr_i, `OFF_DIV)) begin
				div_reg <= wdata_i;
			end else if (buf_wr) begin
				buf_reg <= wdata_i;
			end
			if (coll_pulse_reg || done_pulse_reg || !en_reg) begin
				cmd_reg <= '0;
			end else if (wr_i && hit(addr_i, `OFF_CMD) && idle && cmd_reg == '0) begin
				cmd_reg <= wdata_i[`CMD_ACK:`CMD_START];
			end
			if (wr_i && hit(addr_i, `OFF_CMD)) begin
				ackdt_reg <= wdata_i[`CMD_ACKDT];
			end
		end
	end

	// ==========================================
	// Status flags: set wins over a write-one clear.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			bf_reg <= 1'b0;
			coll_flag_reg <= 1'b0;
			irq_flag_reg <= 1'b0;
			watch_reg <= 1'b0;
		end else if (ce_i) begin
			if (buf_wr) begin
				bf_reg <= 1'b1;
			end else if (coll_pulse_reg || byte_pulse_reg) begin
				bf_reg <= 1'b0;
			end
			if (coll_pulse_reg) begin
				coll_flag_reg <= 1'b1;
			end else if (wr_i && hit(addr_i, `OFF_STAT) && wdata_i[`ST_COLL]) begin
				coll_flag_reg <= 1'b0;
			end
			if (coll_pulse_reg) begin
				watch_reg <= 1'b1;
			end else if (stop_det) begin
				watch_reg <= 1'b0;
			end
			if (done_pulse_reg || byte_pulse_reg) begin
				irq_flag_reg <= 1'b1;
			end else if (stop_det && (watch_reg || (start_seen_reg && ie_reg))) begin
				irq_flag_reg <= 1'b1;
			end else if (wr_i && hit(addr_i, `OFF_STAT) && wdata_i[`ST_IRQ]) begin
				irq_flag_reg <= 1'b0;
			end
		end
	end

	// ==========================================
	// Bus monitor: tracks Start and Stop for bus-free checks.
	// Software uses these to decide when it may take the bus.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_seen_reg <= 1'b0;
			stop_seen_reg <= 1'b0;
		end else if (ce_i) begin
			if (!en_reg) begin
				start_seen_reg <= 1'b0;
				stop_seen_reg <= 1'b0;
			end else if (start_det) begin
				start_seen_reg <= 1'b1;
				stop_seen_reg <= 1'b0;
			end else if (stop_det) begin
				start_seen_reg <= 1'b0;
				stop_seen_reg <= 1'b1;
			end
		end
	end

	// ==========================================
	// Read port and registered outputs.
	// Read data stand for one cycle only, else zero.
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rdata_reg <= `BYTE_ZERO;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			out_reg <= '0;
		end else if (ce_i) begin
			rdata_reg <= `BYTE_ZERO;
			if (rd_i && hit(addr_i, `OFF_CTRL)) begin
				rdata_reg <= {6'h00, ie_reg, en_reg};
			end else if (rd_i && hit(addr_i, `OFF_CMD)) begin
				rdata_reg <= {2'h0, ackstat_reg, ackdt_reg, cmd_reg};
			end else if (rd_i && hit(addr_i, `OFF_STAT)) begin
				rdata_reg <= {2'h0, !idle, irq_flag_reg, coll_flag_reg, bf_reg,
					stop_seen_reg, start_seen_reg};
			end else if (rd_i && hit(addr_i, `OFF_DIV)) begin
				rdata_reg <= div_reg;
			end else if (rd_i && hit(addr_i, `OFF_BUF)) begin
				rdata_reg <= buf_reg;
			end
			irq_reg <= irq_flag_reg && ie_reg;
			// Sleep only gates the wake request.
			wake_reg <= sleep_i && ie_reg && byte_pulse_reg;
		end
	end

	assign rdata_o = rdata_reg;
	assign irq_o = irq_reg;
	assign wake_o = wake_reg;
	assign scl_o = out_reg.scl;
	assign sda_o = out_reg.sda;
	assign scl_oe_n_o = !drv_scl_reg;
	assign sda_oe_n_o = !drv_sda_reg;

	// ==========================================
	// Assertions; they assume ce_i held high.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i || !ce_i);

	sequence s_abort;
		coll_pulse_reg && state_reg == i2c_arb_pkg::S_IDLE;
	endsequence
	sequence s_released;
		!drv_scl_reg && !drv_sda_reg;
	endsequence

	property p_freeze;
		state_reg == i2c_arb_pkg::S_B_REL && !sync2_reg.scl |=> $stable(brg_reg);
	endproperty
	a_freeze: assert property (p_freeze) else $error("baud counter ran while SCL low");
	property p_reload;
		state_reg == i2c_arb_pkg::S_B_REL && sync2_reg.scl && en_reg
			|=> state_reg == i2c_arb_pkg::S_B_HIGH && brg_reg == reload;
	endproperty
	a_reload: assert property (p_reload) else $error("no reload at SCL high");
	property p_lost;
		state_reg == i2c_arb_pkg::S_B_HIGH && en_reg && !drv_sda_reg && !sync2_reg.sda && !ack_slot
			|=> s_abort ##1 (s_released and coll_flag_reg);
	endproperty
	a_lost: assert property (p_lost) else $error("lost arbitration not flagged");
	property p_bf;
		coll_pulse_reg |=> !bf_reg && cmd_reg == '0;
	endproperty
	a_bf: assert property (p_bf) else $error("collision left buffer or enables");
	property p_st_low;
		state_reg == i2c_arb_pkg::S_ST_CHK && en_reg && !(sync2_reg.scl && sync2_reg.sda) |=> s_abort;
	endproperty
	a_st_low: assert property (p_st_low) else $error("start on low line not aborted");
	property p_early;
		state_reg == i2c_arb_pkg::S_ST_C1 && en_reg && !sync2_reg.sda
			|=> drv_sda_reg && brg_reg == reload && !coll_pulse_reg;
	endproperty
	a_early: assert property (p_early) else $error("start did not drive SDA early");
	property p_rs_scl;
		state_reg == i2c_arb_pkg::S_RS_C2 && en_reg && !sync2_reg.scl |=> s_abort;
	endproperty
	a_rs_scl: assert property (p_rs_scl) else $error("SCL fall in repeated start missed");
	property p_seen;
		!en_reg |=> !start_seen_reg && !stop_seen_reg;
	endproperty
	a_seen: assert property (p_seen) else $error("start or stop seen kept when off");
	property p_stop_irq;
		en_reg && stop_det && start_seen_reg && ie_reg |=> irq_flag_reg ##1 irq_o;
	endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("stop on busy bus gave no irq");
	property p_wake;
		sleep_i && ie_reg && byte_pulse_reg |=> wake_o;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake after byte");
endmodule : i2c_arb

// ---- tb/i2c_bus_peer.sv ----
// Bus partner: wired-AND lines with pull-ups and a slave that stretches SCL, captures bytes and acknowledges.
`timescale 1ns/1ps
module i2c_bus_peer (
	input wire logic ref_clk_i,
	input wire logic scl_oe_n_i,
	input wire logic sda_oe_n_i,
	input wire logic sda_low_i,
	input wire logic [7:0] stretch_i,
	output logic scl_o,
	output logic sda_o,
	output logic [7:0] byte_o
);
	// ==========================================
	// Slave state.
	logic scl_hold = 1'b0; // Slave holding SCL low after each falling edge.
	logic ack_hold = 1'b0; // Slave pulling SDA low in the ninth slot.
	logic scl_prev = 1'b1;
	logic sda_prev = 1'b1;
	logic [3:0] bit_cnt = 4'h0;
	logic [7:0] hold_cnt = 8'h00;
	initial byte_o = 8'h00;
	// Released lines float high through the pull-ups; any party may pull low.
	assign scl_o = scl_oe_n_i & ~scl_hold;
	assign sda_o = sda_oe_n_i & ~ack_hold & ~sda_low_i;
	// ==========================================
	// Start or Stop restarts the bit count; rising SCL shifts MSB first.
	always @(posedge ref_clk_i) begin
		scl_prev <= scl_o;
		sda_prev <= sda_o;
		if (scl_o && scl_prev && (sda_prev != sda_o)) begin
			bit_cnt <= 4'h0;
		end else if (scl_o && !scl_prev) begin
			if (bit_cnt == 4'h8) begin
				bit_cnt <= 4'h9;
			end else begin
				byte_o <= {byte_o[6:0], sda_o};
				bit_cnt <= bit_cnt + 4'h1;
			end
		end else if (!scl_o && scl_prev) begin
			// Stretching here is what forces the master to wait before counting high time.
			ack_hold <= (bit_cnt == 4'h8);
			if (bit_cnt == 4'h9) begin
				bit_cnt <= 4'h0;
			end
			hold_cnt <= stretch_i;
			scl_hold <= (stretch_i != 8'h00);
		end else if (hold_cnt > 8'h01) begin
			hold_cnt <= hold_cnt - 8'h01;
		end else begin
			hold_cnt <= 8'h00;
			scl_hold <= 1'b0;
		end
	end
endmodule : i2c_bus_peer

// ---- tb/i2c_master_arbitration_test.sv ----
// Self-checking bench for the arbitrating I2C master against a bus partner.
`timescale 1ns/1ps
`include "i2c_arb_defs.svh"
`define CHK(nm, e, g) begin check_count++; if ((e) !== (g)) begin errors++; $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module i2c_master_arbitration_test;
	typedef struct {string nm; logic [7:0] exp; logic [7:0] msk; bit chk;} note_s;
	localparam logic [7:0] DIV = 8'h03; // Short baud count keeps the run brief.
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic sleep = 1'b0;
	logic sda_low = 1'b0; // Another master pulling SDA low.
	logic [7:0] stretch = 8'h00;
	logic [7:0] rdata, peer_byte, last, d;
	logic scl_oe_n, sda_oe_n, irq, wake, scl_w, sda_w;
	logic rd_d = 1'b0;
	logic ce = 1'b1; // Clock enable; dropped once to show that state freezes.
	logic scl_d, sda_d; // Open-drain data outputs, expected always low.
	logic wake_seen = 1'b0;
	logic meas = 1'b0;
	int hi_len = 0;
	int min_hi = 255;
	int errors = 0;
	int check_count = 0;
	note_s notes[$];
	note_s cur;
	always #2.5 ref_clk_i = ~ref_clk_i;
	i2c_arb uut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .ce_i(ce), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
		.rd_i(rd), .rdata_o(rdata), .scl_i(scl_w), .scl_o(scl_d), .scl_oe_n_o(scl_oe_n), .sda_i(sda_w), .sda_o(sda_d),
		.sda_oe_n_o(sda_oe_n), .sleep_i(sleep), .irq_o(irq), .wake_o(wake));
	i2c_bus_peer peer (.ref_clk_i(ref_clk_i), .scl_oe_n_i(scl_oe_n), .sda_oe_n_i(sda_oe_n), .sda_low_i(sda_low),
		.stretch_i(stretch), .scl_o(scl_w), .sda_o(sda_w), .byte_o(peer_byte));
	// ==========================================
	// Monitor: read data stand one cycle after the strobe; oldest note is compared then.
	always @(posedge ref_clk_i) begin
		rd_d <= rd;
		if (wake) wake_seen <= 1'b1;
		if (scl_w) begin
			hi_len <= hi_len + 1;
		end else begin
			if (meas && hi_len != 0 && hi_len < min_hi) min_hi <= hi_len;
			hi_len <= 0;
		end
		if (rd_d) begin
			last = rdata;
			cur = notes.pop_front();
			if (cur.chk) `CHK(cur.nm, cur.exp, rdata & cur.msk)
		end
	end
	// ==========================================
	// Bus tasks and bounded polling.
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : close_out
	task automatic wreg(input logic [2:0] a, input logic [7:0] v);
		@(posedge ref_clk_i);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge ref_clk_i);
		wr <= 1'b0;
	endtask : wreg
	task automatic rreg(input logic [2:0] a, input string nm, input logic [7:0] e, input logic [7:0] m, input bit c);
		note_s n;
		n = '{nm, e, m, c};
		@(posedge ref_clk_i);
		addr <= a;
		rd <= 1'b1;
		notes.push_back(n);
		@(posedge ref_clk_i);
		rd <= 1'b0;
		@(posedge ref_clk_i);
		#1;
	endtask : rreg
	task automatic poll(input logic [2:0] a, input int b, input logic v);
		for (int k = 0; k < 500; k++) begin
			rreg(a, "poll", 8'h00, 8'h00, 1'b0);
			if (last[b] === v) return;
		end
		errors++;
		$display("[ERR] poll bit %0d expected %h seen %h", b, v, last[b]);
		close_out();
	endtask : poll
	// Issue a Start and wait for it to finish; the caller only does so on a free bus.
	task automatic start_seq();
		wreg(`OFF_CMD, 8'h01 << `CMD_START);
		poll(`OFF_CMD, `CMD_START, 1'b0);
	endtask : start_seq
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		errors++;
		close_out();
	end
	// ==========================================
	// Main sequence.
	initial begin
		void'($urandom(68));
		repeat (8) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rreg(`OFF_STAT, "stat_rst", 8'h00, 8'h1f, 1'b1);
		rreg(`OFF_CTRL, "ctrl_rst", 8'h00, 8'h03, 1'b1);
		rreg(`OFF_DIV, "div_rst", `DIV_RST, 8'hff, 1'b1);
		wreg(3'h6, 8'hff);
		rreg(3'h6, "unmapped", 8'h00, 8'hff, 1'b1);
		wreg(`OFF_DIV, DIV);
		wreg(`OFF_CTRL, 8'h03);
		rreg(`OFF_DIV, "div_rw", DIV, 8'h7f, 1'b1);
		// A write made while the clock enable is low must not land.
		ce <= 1'b0;
		wreg(`OFF_DIV, 8'h55);
		ce <= 1'b1;
		rreg(`OFF_DIV, "ce_hold", DIV, 8'hff, 1'b1);
		$display("test reset done");
		// A line already low when Start begins is a collision.
		sda_low <= 1'b1;
		wreg(`OFF_CMD, 8'h01 << `CMD_START);
		poll(`OFF_STAT, `ST_COLL, 1'b1);
		rreg(`OFF_CMD, "start_clr", 8'h00, 8'h01, 1'b1);
		`CHK("scl_rel", 1'b1, scl_oe_n)
		`CHK("sda_rel", 1'b1, sda_oe_n)
		wreg(`OFF_STAT, 8'h18);
		sda_low <= 1'b0;
		poll(`OFF_STAT, `ST_IRQ, 1'b1);
		wreg(`OFF_STAT, 8'h18);
		$display("test start collision done");
		// Stop was seen, so the bus may be taken.
		start_seq();
		rreg(`OFF_STAT, "start_ok", 8'h01, 8'h09, 1'b1);
		wreg(`OFF_STAT, 8'h10);
		stretch <= 8'(10 + $urandom_range(20));
		sleep <= 1'b1;
		wake_seen <= 1'b0;
		meas <= 1'b1;
		d = 8'($urandom);
		wreg(`OFF_BUF, d);
		poll(`OFF_STAT, `ST_IRQ, 1'b1);
		meas <= 1'b0;
		`CHK("byte", d, peer_byte)
		`CHK("scl_high", 1'b1, min_hi >= int'(DIV) + 1)
		`CHK("wake", 1'b1, wake_seen)
		`CHK("irq_o", 1'b1, irq)
		rreg(`OFF_CMD, "ackstat", 8'h00, 8'h20, 1'b1);
		$display("test stretched byte done");
		// Repeated Start while another master holds SDA low.
		wreg(`OFF_STAT, 8'h10);
		sleep <= 1'b0;
		wreg(`OFF_CMD, 8'h01 << `CMD_RSTART);
		// SDA must first be seen floating high; pull it low while SCL is still held low.
		repeat (3) @(posedge ref_clk_i);
		sda_low <= 1'b1;
		poll(`OFF_STAT, `ST_COLL, 1'b1);
		rreg(`OFF_CMD, "rstart_clr", 8'h00, 8'h02, 1'b1);
		wreg(`OFF_STAT, 8'h18);
		sda_low <= 1'b0;
		poll(`OFF_STAT, `ST_IRQ, 1'b1);
		wreg(`OFF_STAT, 8'h18);
		$display("test repeated start collision done");
		// Lost arbitration on a '1' data bit, then a fresh byte from its first bit.
		start_seq();
		wreg(`OFF_STAT, 8'h10);
		stretch <= 8'h00;
		wreg(`OFF_BUF, 8'h80 | 8'($urandom));
		sda_low <= 1'b1;
		poll(`OFF_STAT, `ST_COLL, 1'b1);
		rreg(`OFF_STAT, "bf_clr", 8'h00, 8'h04, 1'b1);
		`CHK("scl_rel", 1'b1, scl_oe_n)
		`CHK("sda_rel", 1'b1, sda_oe_n)
		wreg(`OFF_STAT, 8'h18);
		sda_low <= 1'b0;
		poll(`OFF_STAT, `ST_IRQ, 1'b1);
		wreg(`OFF_STAT, 8'h18);
		start_seq();
		wreg(`OFF_STAT, 8'h10);
		d = 8'($urandom);
		wreg(`OFF_BUF, d);
		poll(`OFF_STAT, `ST_IRQ, 1'b1);
		`CHK("rewrite", d, peer_byte)
		// Master acknowledge, then a Stop, so that the bus ends free.
		wreg(`OFF_CMD, 8'h01 << `CMD_ACK);
		poll(`OFF_CMD, `CMD_ACK, 1'b0);
		wreg(`OFF_CMD, 8'h01 << `CMD_STOP);
		poll(`OFF_CMD, `CMD_STOP, 1'b0);
		$display("test byte collision done");
		// Disabling the port clears the seen bits.
		rreg(`OFF_STAT, "stop_seen", 8'h02, 8'h02, 1'b1);
		wreg(`OFF_CTRL, 8'h00);
		rreg(`OFF_STAT, "seen_clr", 8'h00, 8'h03, 1'b1);
		$display("test disable done");
		// Reset in mid-byte ends the transfer and disables the port.
		wreg(`OFF_CTRL, 8'h03);
		start_seq();
		wreg(`OFF_BUF, 8'($urandom));
		repeat (10) @(posedge ref_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		`CHK("rst_scl", 1'b1, scl_oe_n)
		`CHK("rst_sda", 1'b1, sda_oe_n)
		`CHK("od_data", 2'b00, {scl_d, sda_d})
		rst_i <= 1'b0;
		rreg(`OFF_CTRL, "rst_ctrl", 8'h00, 8'h03, 1'b1);
		rreg(`OFF_STAT, "rst_stat", 8'h00, 8'h05, 1'b1);
		$display("test reset mid transfer done");
		close_out();
	end
endmodule : i2c_master_arbitration_test
